/* File: async_queue_pkg.sv */
// Constants for the host access block of the asynchronous packet queues.
// Assumes a 32-bit classic Wishbone register bus and byte addresses.
package async_queue_pkg;

  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  localparam int FLAG_WIDTH = 17;

  // Register byte offsets
  localparam logic [7:0] TX_REQUEST_NEXT_QUADLET  = 8'h88;
  localparam logic [7:0] TX_REQUEST_LAST_QUADLET  = 8'h8C;
  localparam logic [7:0] TX_RESPONSE_NEXT_QUADLET = 8'h90;
  localparam logic [7:0] TX_RESPONSE_LAST_QUADLET = 8'h94;
  localparam logic [7:0] RX_REQUEST_QUADLET       = 8'h98;
  localparam logic [7:0] RX_RESPONSE_QUADLET      = 8'h9C;
  localparam logic [7:0] ASYNC_EVENT_FLAGS        = 8'hA0;
  localparam logic [7:0] ASYNC_EVENT_ENABLES      = 8'hA4;

  // Reset values
  localparam logic [31:0] RX_QUADLET_RESET = 32'h0000_0000;
  localparam logic [16:0] FLAGS_RESET      = 17'h00C00;
  localparam logic [16:0] ENABLES_RESET    = 17'h00000;

  // Bit positions in async_event_flags
  localparam int RX_RESPONSE_BECAME_FULL    = 16;
  localparam int RX_REQUEST_BECAME_FULL     = 15;
  localparam int SELF_ID_QUADLET_PRESENT    = 14;
  localparam int RX_RESPONSE_FINAL_QUADLET  = 13;
  localparam int RX_REQUEST_FINAL_QUADLET   = 12;
  localparam int RX_RESPONSE_READ_ERROR     = 11;
  localparam int RX_REQUEST_READ_ERROR      = 10;
  localparam int RESPONSE_QUADLET_AVAILABLE = 9;
  localparam int REQUEST_QUADLET_AVAILABLE  = 8;
  localparam int SPLIT_TIMEOUT              = 7;
  localparam int SOLICITED_RESPONSE_ARRIVED = 6;
  localparam int TX_RESPONSE_BECAME_FULL    = 5;
  localparam int TX_REQUEST_BECAME_FULL     = 4;
  localparam int TX_RESPONSE_WRITE_ERROR    = 3;
  localparam int TX_REQUEST_WRITE_ERROR     = 2;
  localparam int RESPONSE_QUEUE_WRITTEN     = 1;
  localparam int REQUEST_QUEUE_WRITTEN      = 0;

endpackage : async_queue_pkg

/* File: async_queue_host_access.sv */
// Host register access to the asynchronous transmit and receive queues.
// Assumes queue engines on the same clock with valid/ready handshakes and
// a classic Wishbone master; every request is acknowledged one cycle later.
// Operation
// - Write to request-next pushes word as first or middle request quadlet.
// - Write to request-last pushes the word as final request quadlet.
// - Write to response-next pushes word as first or middle response quadlet.
// - Write to response-last pushes the word as final response quadlet.
// - Request write clears request-written until quadlet is queued.
// - Response write clears response-written until quadlet is queued.
// - Reading rx request returns quadlet, clears available flag; resets zero.
// - Reading rx response returns quadlet and clears its available flag.
// - Event flags reset to 0x00000C00; upper unused bits read zero.
// - Bits 16 and 15 latch on rx queue full; write one clears.
// - Bit 14 marks self-ID quadlet after bus reset; clears on read.
// - Bits 13 and 12 mark final quadlet; clear when read.
// - Bits 11 and 10 set on read error or bus reset; block reads.
// - Bits 9 and 8 mark quadlet available; clear when read.
// - Bit 7 latches on split response timeout; write one clears.
// - Bit 6 latches on solicited response in time; write one clears.
// - Bits 5 and 4 latch on tx queue full; write one clears.
// - Bits 3 and 2 latch on tx write error; write one clears.
// - Bits 1 and 0 set when transfer register emptied; write one clears.
// - Enable register gates each flag bit onto the host interrupt.
//
// The Wishbone interface to the registers was chosen for this implementation.
module async_queue_host_access #(
  parameter int ADDR_WIDTH = async_queue_pkg::ADDR_WIDTH
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [ADDR_WIDTH-1:0] adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  output logic      [31:0]           treq_data_o,
  output logic                       treq_last_o,
  output logic                       treq_valid_o,
  input  wire logic                  treq_ready_i,
  output logic      [31:0]           trsp_data_o,
  output logic                       trsp_last_o,
  output logic                       trsp_valid_o,
  input  wire logic                  trsp_ready_i,
  input  wire logic [31:0]           rx_request_quadlet_data_i,
  input  wire logic                  rx_request_quadlet_last_i,
  input  wire logic                  rx_request_quadlet_self_id_i,
  input  wire logic                  rx_request_quadlet_valid_i,
  output logic                       rx_request_quadlet_ready_o,
  input  wire logic [31:0]           rx_response_quadlet_data_i,
  input  wire logic                  rx_response_quadlet_last_i,
  input  wire logic                  rx_response_quadlet_valid_i,
  output logic                       rx_response_quadlet_ready_o,
  input  wire logic                  tx_request_full_i,
  input  wire logic                  tx_response_full_i,
  input  wire logic                  rx_request_full_i,
  input  wire logic                  rx_response_full_i,
  input  wire logic                  rx_request_rd_error_i,
  input  wire logic                  rx_response_rd_error_i,
  input  wire logic                  bus_reset_i,
  input  wire logic                  split_timeout_i,
  input  wire logic                  solicited_response_i,
  output logic                       irq_o
);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] treq_data;
    logic        treq_last;
    logic        treq_valid;
    logic [31:0] trsp_data;
    logic        trsp_last;
    logic        trsp_valid;
    logic [31:0] rx_request_quadlet_data;
    logic [31:0] rx_response_quadlet_data;
    logic        rx_request_quadlet_ready;
    logic        rx_response_quadlet_ready;
    logic [16:0] flags;
    logic [16:0] enables;
    logic [3:0]  full_prev;
    logic        self_id_window;
    logic        irq;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // Word-aligned register match on the byte address
  function automatic logic hit(input logic [ADDR_WIDTH-1:0] adr,
                               input logic [7:0]            offset);
    hit = (adr[ADDR_WIDTH-1:2] == offset[ADDR_WIDTH-1:2]);
  endfunction : hit

  function automatic logic [31:0] lanes(input logic [3:0] sel);
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lanes

  // Flags cleared by writing one; the others clear only on read
  localparam logic [16:0] FLAGS_W1C_MASK = 17'h18CFF;

  logic        req;
  logic        wr;
  logic        rd;
  logic [16:0] set_bits;
  logic [16:0] clr_bits;
  logic [3:0]  full_now;
  logic [3:0]  full_rise;
  logic [31:0] lane_mask;

  always_comb
  begin
    state_next       = state_reg;
    state_next.ack   = 1'b0;
    state_next.rdata = 32'h0000_0000;
    req      = cyc_i && stb_i && !state_reg.ack;
    wr       = req && we_i;
    rd       = req && !we_i;
    set_bits = 17'h00000;
    clr_bits = 17'h00000;
    lane_mask = lanes(sel_i);
    full_now = {rx_response_full_i, rx_request_full_i,
                tx_response_full_i, tx_request_full_i};
    full_rise = full_now & ~state_reg.full_prev;
    state_next.full_prev = full_now;
    state_next.ack = req;

    // Transfer registers emptied into their queues
    if (state_reg.treq_valid && treq_ready_i)
    begin
      state_next.treq_valid = 1'b0;
      set_bits[async_queue_pkg::REQUEST_QUEUE_WRITTEN] = 1'b1;
    end
    if (state_reg.trsp_valid && trsp_ready_i)
    begin
      state_next.trsp_valid = 1'b0;
      set_bits[async_queue_pkg::RESPONSE_QUEUE_WRITTEN] = 1'b1;
    end

    // A write while the quadlet has not moved yet is dropped as an error
    if (wr && (hit(adr_i, async_queue_pkg::TX_REQUEST_NEXT_QUADLET) ||
               hit(adr_i, async_queue_pkg::TX_REQUEST_LAST_QUADLET)))
    begin
      if (state_reg.treq_valid)
      begin
        set_bits[async_queue_pkg::TX_REQUEST_WRITE_ERROR] = 1'b1;
      end
      else
      begin
        state_next.treq_data  = dat_i;
        state_next.treq_valid = 1'b1;
        state_next.treq_last  =
          hit(adr_i, async_queue_pkg::TX_REQUEST_LAST_QUADLET);
        clr_bits[async_queue_pkg::REQUEST_QUEUE_WRITTEN] = 1'b1;
      end
    end
    if (wr && (hit(adr_i, async_queue_pkg::TX_RESPONSE_NEXT_QUADLET) ||
               hit(adr_i, async_queue_pkg::TX_RESPONSE_LAST_QUADLET)))
    begin
      if (state_reg.trsp_valid)
      begin
        set_bits[async_queue_pkg::TX_RESPONSE_WRITE_ERROR] = 1'b1;
      end
      else
      begin
        state_next.trsp_data  = dat_i;
        state_next.trsp_valid = 1'b1;
        state_next.trsp_last  =
          hit(adr_i, async_queue_pkg::TX_RESPONSE_LAST_QUADLET);
        clr_bits[async_queue_pkg::RESPONSE_QUEUE_WRITTEN] = 1'b1;
      end
    end

    // Receive transfer registers load only when empty and not blocked
    if (bus_reset_i)
    begin
      state_next.self_id_window = 1'b1;
      set_bits[async_queue_pkg::RX_REQUEST_READ_ERROR]  = 1'b1;
      set_bits[async_queue_pkg::RX_RESPONSE_READ_ERROR] = 1'b1;
    end
    if (state_reg.rx_request_quadlet_ready && rx_request_quadlet_valid_i)
    begin
      state_next.rx_request_quadlet_data = rx_request_quadlet_data_i;
      set_bits[async_queue_pkg::REQUEST_QUADLET_AVAILABLE] = 1'b1;
      set_bits[async_queue_pkg::RX_REQUEST_FINAL_QUADLET] =
        rx_request_quadlet_last_i;
      // Self-ID marking is only honoured in the window after a bus reset
      set_bits[async_queue_pkg::SELF_ID_QUADLET_PRESENT] =
        rx_request_quadlet_self_id_i && state_reg.self_id_window;
      if (!rx_request_quadlet_self_id_i)
      begin
        state_next.self_id_window = 1'b0;
      end
    end
    if (state_reg.rx_response_quadlet_ready && rx_response_quadlet_valid_i)
    begin
      state_next.rx_response_quadlet_data = rx_response_quadlet_data_i;
      set_bits[async_queue_pkg::RESPONSE_QUADLET_AVAILABLE] = 1'b1;
      set_bits[async_queue_pkg::RX_RESPONSE_FINAL_QUADLET] =
        rx_response_quadlet_last_i;
    end
    set_bits[async_queue_pkg::RX_REQUEST_READ_ERROR] =
      set_bits[async_queue_pkg::RX_REQUEST_READ_ERROR] ||
      rx_request_rd_error_i;
    set_bits[async_queue_pkg::RX_RESPONSE_READ_ERROR] =
      set_bits[async_queue_pkg::RX_RESPONSE_READ_ERROR] ||
      rx_response_rd_error_i;
    set_bits[async_queue_pkg::TX_REQUEST_BECAME_FULL]  = full_rise[0];
    set_bits[async_queue_pkg::TX_RESPONSE_BECAME_FULL] = full_rise[1];
    set_bits[async_queue_pkg::RX_REQUEST_BECAME_FULL]  = full_rise[2];
    set_bits[async_queue_pkg::RX_RESPONSE_BECAME_FULL] = full_rise[3];
    set_bits[async_queue_pkg::SPLIT_TIMEOUT] = split_timeout_i;
    set_bits[async_queue_pkg::SOLICITED_RESPONSE_ARRIVED] =
      solicited_response_i;

    // Register reads; a blocked queue returns zero and keeps its flags
    if (rd)
    begin
      if (hit(adr_i, async_queue_pkg::RX_REQUEST_QUADLET) &&
          !state_reg.flags[async_queue_pkg::RX_REQUEST_READ_ERROR])
      begin
        state_next.rdata = state_reg.rx_request_quadlet_data;
        clr_bits[async_queue_pkg::REQUEST_QUADLET_AVAILABLE] = 1'b1;
        clr_bits[async_queue_pkg::RX_REQUEST_FINAL_QUADLET]  = 1'b1;
        clr_bits[async_queue_pkg::SELF_ID_QUADLET_PRESENT]   = 1'b1;
      end
      if (hit(adr_i, async_queue_pkg::RX_RESPONSE_QUADLET) &&
          !state_reg.flags[async_queue_pkg::RX_RESPONSE_READ_ERROR])
      begin
        state_next.rdata = state_reg.rx_response_quadlet_data;
        clr_bits[async_queue_pkg::RESPONSE_QUADLET_AVAILABLE] = 1'b1;
        clr_bits[async_queue_pkg::RX_RESPONSE_FINAL_QUADLET]  = 1'b1;
      end
      if (hit(adr_i, async_queue_pkg::ASYNC_EVENT_FLAGS))
      begin
        state_next.rdata = {15'h0000, state_reg.flags};
      end
      if (hit(adr_i, async_queue_pkg::ASYNC_EVENT_ENABLES))
      begin
        state_next.rdata = {15'h0000, state_reg.enables};
      end
    end

    // Write-one-to-clear on the sticky bits; auto-clearing bits ignore it
    if (wr && hit(adr_i, async_queue_pkg::ASYNC_EVENT_FLAGS))
    begin
      clr_bits = clr_bits | (dat_i[16:0] & lane_mask[16:0] & FLAGS_W1C_MASK);
    end
    if (wr && hit(adr_i, async_queue_pkg::ASYNC_EVENT_ENABLES))
    begin
      state_next.enables = (state_reg.enables & ~lane_mask[16:0]) |
                           (dat_i[16:0] & lane_mask[16:0]);
    end

    // A hardware event in the cycle of its clear is kept
    state_next.flags = (state_reg.flags & ~clr_bits) | set_bits;
    state_next.rx_request_quadlet_ready =
      !state_next.flags[async_queue_pkg::REQUEST_QUADLET_AVAILABLE] &&
      !state_next.flags[async_queue_pkg::RX_REQUEST_READ_ERROR];
    state_next.rx_response_quadlet_ready =
      !state_next.flags[async_queue_pkg::RESPONSE_QUADLET_AVAILABLE] &&
      !state_next.flags[async_queue_pkg::RX_RESPONSE_READ_ERROR];
    state_next.irq = |(state_next.flags & state_next.enables);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg           <= '0;
      state_reg.rx_request_quadlet_data <= async_queue_pkg::RX_QUADLET_RESET;
      state_reg.rx_response_quadlet_data <= async_queue_pkg::RX_QUADLET_RESET;
      state_reg.flags     <= async_queue_pkg::FLAGS_RESET;
      state_reg.enables   <= async_queue_pkg::ENABLES_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign dat_o        = state_reg.rdata;
  assign ack_o        = state_reg.ack;
  assign treq_data_o  = state_reg.treq_data;
  assign treq_last_o  = state_reg.treq_last;
  assign treq_valid_o = state_reg.treq_valid;
  assign trsp_data_o  = state_reg.trsp_data;
  assign trsp_last_o  = state_reg.trsp_last;
  assign trsp_valid_o = state_reg.trsp_valid;
  assign rx_request_quadlet_ready_o = state_reg.rx_request_quadlet_ready;
  assign rx_response_quadlet_ready_o = state_reg.rx_response_quadlet_ready;
  assign irq_o        = state_reg.irq;

  logic wr_req_next;
  logic wr_req_last;
  logic wr_rsp_any;
  logic rd_rx_request_quadlet;
  assign wr_req_next = cyc_i && stb_i && we_i && !ack_o &&
    hit(adr_i, async_queue_pkg::TX_REQUEST_NEXT_QUADLET);
  assign wr_req_last = cyc_i && stb_i && we_i && !ack_o &&
    hit(adr_i, async_queue_pkg::TX_REQUEST_LAST_QUADLET);
  assign wr_rsp_any = cyc_i && stb_i && we_i && !ack_o &&
    (hit(adr_i, async_queue_pkg::TX_RESPONSE_NEXT_QUADLET) ||
     hit(adr_i, async_queue_pkg::TX_RESPONSE_LAST_QUADLET));
  assign rd_rx_request_quadlet = cyc_i && stb_i && !we_i && !ack_o &&
    hit(adr_i, async_queue_pkg::RX_REQUEST_QUADLET);

  a_push_req_next: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_req_next && !treq_valid_o |=> treq_valid_o && !treq_last_o &&
      treq_data_o == $past(dat_i))
    else $error("request next quadlet not pushed");

  a_push_req_last: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_req_last && !treq_valid_o |=> treq_valid_o && treq_last_o)
    else $error("request last quadlet not marked final");

  a_push_rsp_word: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_rsp_any && !trsp_valid_o |=> trsp_valid_o &&
      trsp_data_o == $past(dat_i))
    else $error("response quadlet not pushed");

  a_req_written_clear: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr_req_next && !treq_valid_o |=>
      !state_reg.flags[async_queue_pkg::REQUEST_QUEUE_WRITTEN]
      until (treq_valid_o && treq_ready_i))
    else $error("request written flag not held clear");

  a_req_written_set: assert property (@(posedge clk_i)
    disable iff (rst_i)
    treq_valid_o && treq_ready_i |=> !treq_valid_o &&
      state_reg.flags[async_queue_pkg::REQUEST_QUEUE_WRITTEN])
    else $error("request written flag not set on move");

  a_rx_request_quadlet_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_rx_request_quadlet && state_reg.flags[async_queue_pkg::REQUEST_QUADLET_AVAILABLE] &&
      !state_reg.flags[async_queue_pkg::RX_REQUEST_READ_ERROR] |=>
      ack_o && dat_o == $past(state_reg.rx_request_quadlet_data) &&
      !state_reg.flags[async_queue_pkg::REQUEST_QUADLET_AVAILABLE])
    else $error("rx request read did not return and clear");

  a_flags_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> state_reg.flags == async_queue_pkg::FLAGS_RESET)
    else $error("event flags wrong after reset");

  a_rx_full_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(rx_response_full_i) |=>
      state_reg.flags[async_queue_pkg::RX_RESPONSE_BECAME_FULL])
    else $error("rx response full not latched");

  a_err_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg.flags[async_queue_pkg::RX_REQUEST_READ_ERROR] |-> !rx_request_quadlet_ready_o)
    else $error("blocked request queue still accepts");

  a_timeout_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    split_timeout_i |=> state_reg.flags[async_queue_pkg::SPLIT_TIMEOUT])
    else $error("timeout not latched");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after request");

  c_req_packet: cover property (@(posedge clk_i) disable iff (rst_i)
    wr_req_next ##[1:50] wr_req_last);
  c_rx_request_quadlet_read: cover property (@(posedge clk_i) disable iff (rst_i)
    rx_request_quadlet_valid_i && rx_request_quadlet_ready_o ##[1:20] rd_rx_request_quadlet);
  c_bus_reset: cover property (@(posedge clk_i) disable iff (rst_i)
    bus_reset_i);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));

endmodule : async_queue_host_access

/* File: async_queue_model.sv */
// Behavioural queue engines at the far side of the host access block.
// Assumes one clock; the bench offers rx words and stalls tx acceptance.
module async_queue_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        stall_i,
  input  wire logic        give_i,
  input  wire logic        self_id_i,
  input  wire logic        treq_valid_i,
  input  wire logic [31:0] treq_data_i,
  input  wire logic        treq_last_i,
  output logic             treq_ready_o,
  input  wire logic        trsp_valid_i,
  input  wire logic [31:0] trsp_data_i,
  input  wire logic        trsp_last_i,
  output logic             trsp_ready_o,
  input  wire logic        rx_request_quadlet_ready_i,
  output logic      [31:0] rx_request_quadlet_data_o,
  output logic             rx_request_quadlet_last_o,
  output logic             rx_request_quadlet_self_id_o,
  output logic             rx_request_quadlet_valid_o,
  input  wire logic        rx_response_quadlet_ready_i,
  output logic      [31:0] rx_response_quadlet_data_o,
  output logic             rx_response_quadlet_last_o,
  output logic             rx_response_quadlet_valid_o,
  output logic      [32:0] got_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] seq_q;
  logic [7:0] seq_p;
  logic       pend_q;
  logic       pend_p;
  logic       sid_q;

  assign treq_ready_o = !stall_i;
  assign trsp_ready_o = !stall_i;
  assign rx_request_quadlet_valid_o = pend_q;
  assign rx_response_quadlet_valid_o = pend_p;
  assign rx_request_quadlet_last_o = seq_q[0];
  assign rx_response_quadlet_last_o = seq_p[0];
  assign rx_request_quadlet_self_id_o = sid_q;
  // An idle word line shows the inverse so a stale value never passes
  assign rx_request_quadlet_data_o = pend_q ? {8'hA1, 16'h0000, seq_q}
                              : ~{8'hA1, 16'h0000, seq_q};
  assign rx_response_quadlet_data_o = pend_p ? {8'hB2, 16'h0000, seq_p}
                              : ~{8'hB2, 16'h0000, seq_p};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seq_q <= 8'h00;
      seq_p <= 8'h00;
      pend_q <= 1'b0;
      pend_p <= 1'b0;
      sid_q <= 1'b0;
      got_o <= 33'h0_0000_0000;
    end
    else
    begin
      if (pend_q && rx_request_quadlet_ready_i)
      begin
        pend_q <= 1'b0;
        seq_q <= seq_q + 8'h01;
      end
      else if (give_i)
      begin
        pend_q <= 1'b1;
        sid_q <= self_id_i;
      end
      if (pend_p && rx_response_quadlet_ready_i)
      begin
        pend_p <= 1'b0;
        seq_p <= seq_p + 8'h01;
      end
      else if (give_i)
        pend_p <= 1'b1;
      if (treq_valid_i && treq_ready_o)
        got_o <= {treq_last_i, treq_data_i};
      if (trsp_valid_i && trsp_ready_o)
        got_o <= {trsp_last_i, trsp_data_i};
    end
  end
endmodule : async_queue_model

/* File: async_queue_host_access_tb.sv */
// Self-checking bench for the host access block of the async queues.
// Assumes the design package and the queue model are compiled first.
module async_queue_host_access_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FLG = async_queue_pkg::ASYNC_EVENT_FLAGS;
  localparam logic [7:0] ENB = async_queue_pkg::ASYNC_EVENT_ENABLES;
  localparam logic [7:0] RA [6] = '{8'hA0, 8'hA4, 8'h98, 8'h9C, 8'h88, 8'hFC};
  localparam logic [31:0] RE [6] = '{32'h0000_0C00, 32'h0, 32'h0, 32'h0,
                                     32'h0, 32'h0};
  localparam int EB [8] = '{4, 5, 15, 16, 7, 6, 10, 11};
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [7:0]  ev = 8'h00;
  logic        bus_reset_i = 1'b0;
  logic        stall = 1'b0;
  logic        give = 1'b0;
  logic        sid = 1'b0;
  logic [31:0] dat_o, treq_data_o, trsp_data_o, rx_request_quadlet_data_i, rx_response_quadlet_data_i;
  logic        ack_o, treq_last_o, treq_valid_o, treq_ready_i, trsp_last_o;
  logic        trsp_valid_o, trsp_ready_i, rx_request_quadlet_last_i, rx_request_quadlet_self_id_i;
  logic        rx_request_quadlet_valid_i, rx_request_quadlet_ready_o, rx_response_quadlet_last_i, rx_response_quadlet_valid_i;
  logic        rx_response_quadlet_ready_o, irq_o;
  logic [32:0] got;
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed = 82127;

  async_queue_host_access dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .treq_data_o, .treq_last_o,
    .treq_valid_o, .treq_ready_i, .trsp_data_o, .trsp_last_o, .trsp_valid_o,
    .trsp_ready_i, .rx_request_quadlet_data_i, .rx_request_quadlet_last_i, .rx_request_quadlet_self_id_i,
    .rx_request_quadlet_valid_i, .rx_request_quadlet_ready_o, .rx_response_quadlet_data_i, .rx_response_quadlet_last_i, .rx_response_quadlet_valid_i,
    .rx_response_quadlet_ready_o, .tx_request_full_i(ev[0]), .tx_response_full_i(ev[1]),
    .rx_request_full_i(ev[2]), .rx_response_full_i(ev[3]),
    .split_timeout_i(ev[4]), .solicited_response_i(ev[5]),
    .rx_request_rd_error_i(ev[6]), .rx_response_rd_error_i(ev[7]),
    .bus_reset_i, .irq_o);

  async_queue_model far (.clk_i, .rst_i, .stall_i(stall), .give_i(give),
    .self_id_i(sid), .treq_valid_i(treq_valid_o), .treq_data_i(treq_data_o),
    .treq_last_i(treq_last_o), .treq_ready_o(treq_ready_i),
    .trsp_valid_i(trsp_valid_o), .trsp_data_i(trsp_data_o),
    .trsp_last_i(trsp_last_o), .trsp_ready_o(trsp_ready_i),
    .rx_request_quadlet_ready_i(rx_request_quadlet_ready_o), .rx_request_quadlet_data_o(rx_request_quadlet_data_i),
    .rx_request_quadlet_last_o(rx_request_quadlet_last_i), .rx_request_quadlet_self_id_o(rx_request_quadlet_self_id_i),
    .rx_request_quadlet_valid_o(rx_request_quadlet_valid_i), .rx_response_quadlet_ready_i(rx_response_quadlet_ready_o),
    .rx_response_quadlet_data_o(rx_response_quadlet_data_i), .rx_response_quadlet_last_o(rx_response_quadlet_last_i),
    .rx_response_quadlet_valid_o(rx_response_quadlet_valid_i), .got_o(got));

  always #5 clk_i = ~clk_i;

  task automatic test_done();
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h, want %h", $time, what, seen, exp);
    end
  endtask : check

  // Classic single cycle; the answer is awaited, never assumed
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    adr_i <= adr;
    dat_i <= wd;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] v;
    wb(1'b1, adr, d, v);
  endtask : wr

  task automatic chk(input logic [7:0] adr, input logic [31:0] mask,
                     input logic [31:0] exp, input string what);
    logic [31:0] v;
    wb(1'b0, adr, 32'h0, v);
    check(v & mask, exp, what);
  endtask : chk

  function automatic logic [31:0] rxw(input bit rsp, input int s);
    return {rsp ? 8'hB2 : 8'hA1, 16'h0000, 8'(s)};
  endfunction : rxw

  initial
  begin
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] o;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(8'hFC, ALL);
    for (int i = 0; i < 6; i++)
      chk(RA[i], ALL, RE[i], "reset value");
    wr(FLG, ALL);
    chk(FLG, ALL, 32'h0, "all ones cleared, upper zero");
    wr(ENB, ALL);
    chk(ENB, ALL, 32'h0001_FFFF, "enable width");
    for (int k = 0; k < 8; k++)
    begin
      wr(ENB, 32'h0001_FFFF ^ (32'h1 << EB[k]));
      @(posedge clk_i);
      ev[k] <= 1'b1;
      @(posedge clk_i);
      ev[k] <= 1'b0;
      chk(FLG, ALL, 32'h1 << EB[k], "event latch");
      check({31'h0, irq_o}, 32'h0, "masked event");
      wr(ENB, 32'h1 << EB[k]);
      repeat (2) @(posedge clk_i);
      check({31'h0, irq_o}, 32'h1, "enabled event");
      wr(FLG, 32'h1 << EB[k]);
      chk(FLG, ALL, 32'h0, "write one clear");
      check({31'h0, irq_o}, 32'h0, "cleared event");
    end
    wr(ENB, 32'h0);
    @(posedge clk_i);
    bus_reset_i <= 1'b1;
    @(posedge clk_i);
    bus_reset_i <= 1'b0;
    sid <= 1'b1;
    give <= 1'b1;
    @(posedge clk_i);
    give <= 1'b0;
    chk(FLG, 32'h0000_0C00, 32'h0000_0C00, "bus reset");
    check({30'h0, rx_request_quadlet_ready_o, rx_response_quadlet_ready_o}, 32'h0, "blocked");
    chk(8'h98, ALL, 32'h0, "blocked read");
    wr(FLG, 32'h0000_0C00);
    for (int j = 0; j < 2; j++)
    begin
      if (j == 1)
      begin
        @(posedge clk_i);
        sid <= 1'b0;
        give <= 1'b1;
        @(posedge clk_i);
        give <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      chk(FLG, 32'h7300, 32'h300 | (j << 12) | (j << 13) | ((1 - j) << 14),
          "rx arrival");
      chk(8'h98, ALL, rxw(0, j), "rx request word");
      chk(8'h9C, ALL, rxw(1, j), "rx response word");
      chk(FLG, 32'h7300, 32'h0, "clear on read");
    end
    for (int i = 0; i < 4; i++)
    begin
      a = 8'h88 + 8'(4 * i);
      d = $random(seed);
      // Request written flag is left set once the response queue is used
      o = (i >= 2) ? 32'h1 : 32'h0;
      @(posedge clk_i);
      stall <= 1'b1;
      wr(a, d);
      check(i < 2 ? treq_data_o : trsp_data_o, d, "tx word");
      check({30'h0, i < 2 ? {treq_last_o, treq_valid_o} : {trsp_last_o,
            trsp_valid_o}}, {30'h0, i[0], 1'b1}, "tx flags");
      chk(FLG, 32'h3, o, "written flag low");
      // Second word before the flag returns is refused on purpose
      wr(a, ~d);
      chk(FLG, 32'hF, (32'h1 << (2 + i / 2)) | o, "write error");
      @(posedge clk_i);
      stall <= 1'b0;
      repeat (3) @(posedge clk_i);
      check(got[31:0], d, "queued word");
      check({31'h0, got[32]}, {31'h0, i[0]}, "queued last");
      chk(FLG, 32'hF, (32'h1 << (i / 2)) | (32'h4 << (i / 2)) | o,
          "written flag back");
      // Write error flags stay set so the next write must clear them
      wr(FLG, 32'hC);
      chk(FLG, 32'hF, (32'h1 << (i / 2)) | o, "tx flags clear");
    end
    test_done();
  end
endmodule : async_queue_host_access_tb
